// *** hw/encoder_count_device.sv ***
/*
  device end: quadrature counter, position latch, inhibit logic, byte
  multiplexer with three-state drive, cascade pulse and direction.
  assumes phase inputs are asynchronous pins and the host changes
  select and enable in step with clk.
*/
// Behaviour
// - select held high: latch tracks every edge
// - host drives select, enable on clock
// - latch loads counter while inhibit low
// - enable low drives high/low byte
// - enable and select low set inhibit
// - select high, enable low: first release
// - then enable high clears inhibit
// - enable high floats all data lines
// - counter keeps counting during inhibit
// - host reads high byte then low
// - host may sample bus any time; here a byte is valid only from the falling edge after select moves
// - latch reloads on next rising edge
// - overflow gives cascade pulse with direction
// - external hold loads on low read
// - clear resets inhibit and latch
// - narrow variant zeroes upper high bits
// - half-cycle pulse, direction stable around
`timescale 1ns/1ps
module encoder_count_device #(
  parameter int unsigned COUNT_WIDTH = count_port_pkg::COUNT_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  count_port_if.device port
);
  // inhibit sequencing states
  typedef enum logic [2:0] {
    ST_OPEN = 3'b001,
    ST_HELD = 3'b010,
    ST_RELEASING = 3'b100
  } inhibit_state_t;

  logic [1:0] a_sync_q, b_sync_q;
  logic [1:0] phase_prev_q;
  logic step_valid_q, step_up_q;
  logic [COUNT_WIDTH-1:0] count_q;
  logic [15:0] latch_q;
  inhibit_state_t inh_q, inh_d;
  logic carry_q, carry_neg_q;
  logic dir_q;
  logic [7:0] data_q;
  logic clr_n;

  assign clr_n = reset_n & port.clear_n;

  // two-flop synchronisers on the encoder pins; previous phase kept across a
  // clear so that a clear never fakes a step
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_sync_q <= 2'b00;
      b_sync_q <= 2'b00;
      phase_prev_q <= 2'b00;
    end else if (clk_en) begin
      a_sync_q <= {a_sync_q[0], phase_a_input};
      b_sync_q <= {b_sync_q[0], phase_b_input};
      phase_prev_q <= {a_sync_q[1], b_sync_q[1]};
    end
  end

  // 4x quadrature decode: gray step forward or back
  wire [1:0] phase_now = {a_sync_q[1], b_sync_q[1]};
  wire step_valid = (phase_now[0] ^ phase_now[1] ^ phase_prev_q[0] ^ phase_prev_q[1]);
  wire step_up = (phase_prev_q[1] ^ phase_now[0]);
  wire [COUNT_WIDTH-1:0] count_next = step_up_q ? count_q + 1'b1 : count_q - 1'b1;
  wire wrap = step_valid_q &&
    (step_up_q ? (count_q == {COUNT_WIDTH{1'b1}}) : (count_q == '0));

  // counts while inhibited; step registered so direction leads by a clock
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      count_q <= count_port_pkg::COUNT_RESET[COUNT_WIDTH-1:0];
      step_valid_q <= 1'b0;
      step_up_q <= 1'b0;
    end else if (clk_en) begin
      step_valid_q <= step_valid;
      step_up_q <= step_up;
      if (step_valid_q) begin
        count_q <= count_next;
      end
    end
  end

  // inhibit next state, decided on falling edge samples
  always_comb begin
    inh_d = inh_q;
    unique case (inh_q)
      ST_OPEN: if (!port.out_enable_n && !port.byte_sel) inh_d = ST_HELD;
      ST_HELD: if (!port.out_enable_n && port.byte_sel) inh_d = ST_RELEASING;
      ST_RELEASING: if (port.out_enable_n) inh_d = ST_OPEN;
      default: inh_d = ST_OPEN;
    endcase
  end

  always_ff @(negedge clk or negedge clr_n) begin
    if (!clr_n) begin
      inh_q <= ST_OPEN;
    end else if (clk_en) begin
      inh_q <= inh_d;
    end
  end

  // select stuck high never leaves ST_OPEN, so latch always tracks
  wire inhibit = (inh_q != ST_OPEN);

  // latch loads when inhibit low; narrow count zero-extends
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      latch_q <= count_port_pkg::LATCH_RESET;
    end else if (clk_en && !inhibit) begin
      latch_q <= 16'(count_q);
    end
  end

  // byte mux; registered so data comes from flops
  wire [7:0] byte_pick = port.byte_sel ?
    latch_q[count_port_pkg::LOW_BYTE_LSB +: 8] :
    latch_q[count_port_pkg::HIGH_BYTE_LSB +: 8];
  always_ff @(negedge clk or negedge clr_n) begin
    if (!clr_n) begin
      data_q <= 8'h00;
    end else if (clk_en) begin
      data_q <= byte_pick;
    end
  end
  // falling-edge copy settles before the host samples on the rising edge
  assign port.data_out = data_q;
  assign port.data_oe = !port.out_enable_n;

  // carry pulse: high in first half of the update cycle
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      carry_q <= 1'b0;
      dir_q <= 1'b1;
    end else if (clk_en) begin
      carry_q <= wrap;
      if (step_valid) begin
        dir_q <= step_up;
      end
    end
  end
  always_ff @(negedge clk or negedge clr_n) begin
    if (!clr_n) begin
      carry_neg_q <= 1'b0;
    end else if (clk_en) begin
      carry_neg_q <= carry_q;
    end
  end
  // half-cycle: set on rising edge, masked after the falling edge
  assign port.carry_pulse_out = carry_q & ~carry_neg_q;
  assign port.count_up = dir_q;
endmodule

// *** common/count_port_pkg.sv ***
/*
  shared constants for the encoder count byte read port: count widths,
  byte layout, reset values and the cascade-pulse phase.
  assumes both ends run on one 125 MHz clock.
*/
package count_port_pkg;
  localparam int unsigned COUNT_WIDTH = 16;   // 12 or 16
  localparam int unsigned BYTE_WIDTH = 8;
  localparam int unsigned LOW_BYTE_LSB = 0;
  localparam int unsigned HIGH_BYTE_LSB = 8;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET = 8'h00;
  // cascade pulse lasts half a clock: one period split into two phases
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned CARRY_HALF_CYCLES = 1;
endpackage

// *** common/count_port_if.sv ***
/*
  interface joining the counting device and the reading host.
  the data bus is three-state: the testbench resolves its level
  from data_out and data_oe.
*/
`timescale 1ns/1ps
interface count_port_if;
  logic byte_sel;          // high selects low byte
  logic out_enable_n;      // low drives the bus
  logic [7:0] data_out;    // device drive value
  logic data_oe;           // device drives the bus when high
  logic [7:0] data_in;     // bus level seen by host
  logic carry_pulse_out;   // overflow/underflow half-cycle pulse
  logic count_up;          // direction, high counts up
  logic clear_n;           // asynchronous clear from host

  modport device (
    input byte_sel,
    input out_enable_n,
    input clear_n,
    output data_out,
    output data_oe,
    output carry_pulse_out,
    output count_up
  );
  modport host (
    output byte_sel,
    output out_enable_n,
    output clear_n,
    input data_in,
    input carry_pulse_out,
    input count_up
  );
endinterface

// *** hw/count_reader_host.sv ***
/*
  host end: reads the count as high byte then low byte, extends it with
  an external 8-bit cascade counter and returns a 24-bit word.
  assumes the device shares clk; strobes change on rising edges so the
  device sees them stable on falling edges.
*/
`timescale 1ns/1ps
module count_reader_host (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic read_req,
  input wire logic clear_req,
  output logic read_busy,
  output logic read_done,
  output logic [23:0] read_count,
  count_port_if.host port
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HIGH = 4'b0010,
    ST_LOW = 4'b0100,
    ST_END = 4'b1000
  } read_state_t;

  read_state_t st_q, st_d;
  logic [7:0] ext_q, hold_q, hi_q;
  logic [23:0] count_q;
  logic done_q;
  logic carry_q;

  // high byte first, then low, then release
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (read_req) st_d = ST_HIGH;
      ST_HIGH: st_d = ST_LOW;
      ST_LOW: st_d = ST_END;
      ST_END: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // strobes are decoded from state flops so they move on rising edges
  assign port.out_enable_n = !(st_q == ST_HIGH || st_q == ST_LOW);
  assign port.byte_sel = (st_q != ST_HIGH);
  assign port.clear_n = !clear_req;
  // holding load strobe on the low-byte read
  wire holding_register_load = (st_q == ST_LOW);
  assign read_busy = (st_q != ST_IDLE);
  assign read_done = done_q;
  assign read_count = count_q;

  // carry is high only in the first half cycle: catch it on the falling edge
  always_ff @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      carry_q <= 1'b0;
    end else if (clk_en) begin
      carry_q <= port.carry_pulse_out;
    end
  end

  // external cascade counter, counts the caught carry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      ext_q <= count_port_pkg::EXT_RESET;
      hold_q <= count_port_pkg::HOLD_RESET;
      hi_q <= 8'h00;
      count_q <= 24'h000000;
      done_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      done_q <= 1'b0;
      if (carry_q) begin
        ext_q <= port.count_up ? ext_q + 8'h01 : ext_q - 8'h01;
      end
      // latched data is stable, sample once per byte
      if (st_q == ST_HIGH) begin
        hi_q <= port.data_in;
      end
      if (holding_register_load) begin
        hold_q <= ext_q;
        count_q <= {ext_q, hi_q, port.data_in};
        done_q <= 1'b1;
      end
    end
  end
endmodule

// *** verif/count_port_props.sv ***
/* checker for the count read port interface between the two ends.
   sees interface signals only; one clock, async active-low reset. */
`timescale 1ns/1ps
module count_port_props #(
  parameter int unsigned COUNT_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic byte_sel,
  input wire logic out_enable_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic carry_pulse_out,
  input wire logic count_up,
  input wire logic clear_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // three-state drive follows the enable
  AST_FLOAT: assert property (out_enable_n |-> !data_oe)
    else $error("bus driven while disabled");
  AST_DRIVE: assert property (!out_enable_n |-> data_oe)
    else $error("bus not driven while enabled");
  // high byte first, then low byte, then release
  AST_ORDER: assert property ($fell(out_enable_n) |-> !byte_sel ##1
    (byte_sel && !out_enable_n) ##1 out_enable_n) else $error("bad read order");
  AST_IDLE: assert property ($rose(out_enable_n) |=> out_enable_n)
    else $error("no idle cycle between reads");
  // pulse lives in the high phase only, so it is low at rising edges
  AST_CARRY: assert property (!carry_pulse_out)
    else $error("carry pulse longer than half a cycle");
  AST_DIR: assert property (@(negedge clk) disable iff (!reset_n)
    carry_pulse_out |-> $stable(count_up)) else $error("direction moved at carry");
  AST_CLEAR: assert property (!clear_n |-> data_out == 8'h00 && count_up)
    else $error("clear did not empty the latch");
  AST_NIBBLE: assert property (COUNT_WIDTH == 12 && !byte_sel |->
    data_out[7:4] == 4'h0) else $error("upper nibble not zero");
endmodule

// *** verif/tb.sv ***
/* testbench: device and host joined by the interface, driven from the
   user side. assumes an 8 ns clock and that both ends share it. */
`timescale 1ns/1ps
`define chk(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic phase_a = 1'b0;
  logic phase_b = 1'b0;
  logic read_req = 1'b0;
  logic clear_req = 1'b0;
  logic read_busy;
  logic read_done;
  logic [23:0] read_count;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int idx = 0;
  count_port_if port_if ();
  // a released bus shows a moving pattern, never the last byte
  assign port_if.data_in = port_if.data_oe ? port_if.data_out : {4'ha, {4{clk}}};
  encoder_count_device u_encoder_count_device (.clk(clk), .reset_n(reset_n),
    .clk_en(1'b1), .phase_a_input(phase_a), .phase_b_input(phase_b), .port(port_if));
  count_reader_host u_count_reader_host (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .read_req(read_req), .clear_req(clear_req), .read_busy(read_busy),
    .read_done(read_done), .read_count(read_count), .port(port_if));
  count_port_props u_count_port_props (.clk(clk), .reset_n(reset_n),
    .byte_sel(port_if.byte_sel), .out_enable_n(port_if.out_enable_n),
    .data_out(port_if.data_out), .data_oe(port_if.data_oe),
    .carry_pulse_out(port_if.carry_pulse_out), .count_up(port_if.count_up),
    .clear_n(port_if.clear_n));
  // free-running clock and a cycle ceiling against hangs
  initial forever #4 clk = ~clk;
  initial forever begin
    @(posedge clk);
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // inputs always change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic phase(input bit up);
    idx = up ? (idx + 1) % 4 : (idx + 3) % 4;
    phase_a = (idx >= 2);
    phase_b = (idx == 1) || (idx == 2);
  endtask
  // steps are spaced wider than the two-flop sync needs
  task automatic step(input int n, input bit up);
    repeat (n) begin
      phase(up);
      tick(3);
    end
    tick(4);
  endtask
  task automatic rd(input logic [23:0] exp);
    read_req = 1'b1;
    tick(1);
    read_req = 1'b0;
    `chk("read_busy", 1'b1, read_busy)
    tick(2);
    `chk("read_done", 1'b1, read_done)
    `chk("read_count", exp, read_count)
    `chk("bus float", 1'b0, port_if.data_oe)
    tick(1);
  endtask
  // count moves while a read holds the latch
  task automatic scn_inhibit();
    phase(1'b1);
    tick(2);
    read_req = 1'b1;
    tick(1);
    read_req = 1'b0;
    tick(2);
    `chk("held count", 24'h000005, read_count)
    tick(5);
    rd(24'h000006);
  endtask
  task automatic scn_clear();
    step(3, 1'b1);
    clear_req = 1'b1;
    tick(2);
    clear_req = 1'b0;
    tick(2);
    rd(24'h000000);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    tick(1);
    rd(24'h000000);
    step(5, 1'b1);
    rd(24'h000005);
    scn_inhibit();
    rd(24'h000006);
    step(7, 1'b0);
    rd(24'hffffff);
    step(1, 1'b1);
    rd(24'h000000);
    scn_clear();
    print_verdict();
  end
endmodule
